// File: logic/dmul_stage.sv
// Purpose: multiplier stage: input registers, multipliers, pipeline
// Assumes: all inputs synchronous to clk_in; configuration static
// Notes:
`timescale 1ns/1ps
`include "dmul_cfg.svh"
module dmul_stage (
   input  wire logic                   clk_in,
   input  wire logic                   rstn_in,
   input  wire logic [3:0]             clk_tick_in,
   input  wire logic [3:0]             aclr_in,
   input  wire logic [3:0]             ena_in,
   input  wire dmul_pkg::dmul_mode_t   mode_in,
   input  wire logic [71:0]            a_in,
   input  wire logic [71:0]            b_in,
   input  wire logic [17:0]            chain_in_a_in,
   input  wire logic [17:0]            chain_in_b_in,
   input  wire logic [3:0]             a_use_reg_in,
   input  wire logic [3:0]             b_use_reg_in,
   input  wire logic [7:0]             a_shift_in,
   input  wire logic [7:0]             b_shift_in,
   input  wire logic [7:0]             a_clk_sel_in,
   input  wire logic [7:0]             a_clr_sel_in,
   input  wire logic [7:0]             a_ena_sel_in,
   input  wire logic [7:0]             b_clk_sel_in,
   input  wire logic [7:0]             b_clr_sel_in,
   input  wire logic [7:0]             b_ena_sel_in,
   input  wire logic                   sign_a_in,
   input  wire logic                   sign_b_in,
   input  wire dmul_pkg::dmul_sgn_src_t sign_src_a_in,
   input  wire dmul_pkg::dmul_sgn_src_t sign_src_b_in,
   input  wire logic                   sign_use_reg_in,
   input  wire logic [5:0]             sign_sel_in,
   input  wire logic [3:0]             pipe_use_in,
   input  wire logic [5:0]             pipe_sel_in,
   input  wire logic                   route_adder_in,
   output logic      [17:0]            chain_out_operand_a_out,
   output logic      [17:0]            chain_out_operand_b_out,
   output logic      [143:0]           direct_out,
   output logic      [143:0]           adder_out,
   output logic                        product_signed_out,
   output logic      [5:0]             width_a_out,
   output logic      [5:0]             width_b_out
);
   dmul_ctl_if ctl (.clk(clk_in), .rstn(rstn_in));
   assign ctl.tick = clk_tick_in;
   assign ctl.aclr = aclr_in;
   assign ctl.ena  = ena_in;

   wire is36 = (mode_in == dmul_pkg::DMUL_M36);
   wire is9  = (mode_in == dmul_pkg::DMUL_M9);

   // Operand 0 is A, operand 1 is B
   wire [1:0][71:0] op_in  = {b_in, a_in};
   wire [1:0][17:0] ch_in  = {chain_in_b_in, chain_in_a_in};
   wire [1:0][3:0]  use_r  = {b_use_reg_in, a_use_reg_in};
   wire [1:0][7:0]  shift  = {b_shift_in, a_shift_in};
   wire [1:0][7:0]  sel_c  = {b_clk_sel_in, a_clk_sel_in};
   wire [1:0][7:0]  sel_r  = {b_clr_sel_in, a_clr_sel_in};
   wire [1:0][7:0]  sel_e  = {b_ena_sel_in, a_ena_sel_in};

   wire [1:0][7:0][8:0] op_c9;
   wire [1:0][7:0][8:0] op_c18;
   wire [1:0][7:0][8:0] op_d;
   wire [1:0][7:0][8:0] op_q;
   wire [1:0][7:0][8:0] op_r;
   wire [1:0][7:0]      sh_eff;

   for (genvar o = 0; o < 2; o++) begin : g_op
      for (genvar i = 0; i < `DMUL_LANES; i++) begin : g_lane
         localparam int G = i / 2;
         if (i == 0) begin : g_first
            assign op_c9[o][i]  = ch_in[o][17:9];
            assign op_c18[o][i] = ch_in[o][8:0];
         end else if (i == 1) begin : g_second
            assign op_c9[o][i]  = op_r[o][0];
            assign op_c18[o][i] = ch_in[o][17:9];
         end else begin : g_rest
            assign op_c9[o][i]  = op_r[o][i-1];
            assign op_c18[o][i] = op_r[o][i-2];
         end
         // Per-lane shift in 9-bit mode, per-group in 18-bit mode, lets a chain end at any multiplier
         assign sh_eff[o][i] = ~is36 & (is9 ? shift[o][i]
                                            : shift[o][2*G]);
         // Each operand chooses shift or parallel on its own
         assign op_d[o][i] = sh_eff[o][i]
                           ? (is9 ? op_c9[o][i] : op_c18[o][i])
                           : op_in[o][9*i +: 9];
         dmul_reg #(.W(`DMUL_W9)) u_in (
            .ctl        (ctl),
            .use_in     (use_r[o][G]),
            .clk_sel_in (sel_c[o][2*G +: 2]),
            .clr_sel_in (sel_r[o][2*G +: 2]),
            .ena_sel_in (sel_e[o][2*G +: 2]),
            .d_in       (op_d[o][i]),
            .q_out      (op_q[o][i]),
            .r_out      (op_r[o][i])
         );
      end
   end

   // Chain taps the last registers directly; 9-bit mode uses upper half
   assign chain_out_operand_a_out = {op_r[0][7], op_r[0][6]};
   assign chain_out_operand_b_out = {op_r[1][7], op_r[1][6]};

   // Shared sign controls, optionally registered once
   wire [1:0] sgn_q;
   dmul_reg #(.W(2)) u_sign (
      .ctl        (ctl),
      .use_in     (sign_use_reg_in),
      .clk_sel_in (sign_sel_in[1:0]),
      .clr_sel_in (sign_sel_in[3:2]),
      .ena_sel_in (sign_sel_in[5:4]),
      .d_in       ({sign_b_in, sign_a_in}),
      .q_out      (sgn_q),
      .r_out      ()
   );

   function automatic logic pick(input dmul_pkg::dmul_sgn_src_t s,
                                 input logic [1:0] dyn);
      logic v;
      v = 1'b0;
      unique case (s)
         dmul_pkg::DMUL_SRC_UNS:   v = 1'b0;
         dmul_pkg::DMUL_SRC_SGN:   v = 1'b1;
         dmul_pkg::DMUL_SRC_DYN_A: v = dyn[0];
         dmul_pkg::DMUL_SRC_DYN_B: v = dyn[1];
      endcase
      return v;
   endfunction

   function automatic logic [5:0] wlim(input dmul_pkg::dmul_sgn_src_t s,
                                       input dmul_pkg::dmul_sgn_src_t t);
      logic s_dyn;
      logic t_dyn;
      logic cut;
      s_dyn = s[1];
      t_dyn = t[1];
      cut   = ((s == dmul_pkg::DMUL_SRC_UNS) && (t != dmul_pkg::DMUL_SRC_UNS))
           || (s_dyn && ((t == dmul_pkg::DMUL_SRC_SGN) || (t_dyn && t != s)));
      return cut ? `DMUL_LIM_CUT : `DMUL_LIM_FULL;
   endfunction

   // Same two signs drive every multiplier of the block; in wide mode only the high operand halves keep them
   wire sa = pick(sign_src_a_in, sgn_q);
   wire sb = pick(sign_src_b_in, sgn_q);

   wire [1:0][35:0] o36 = {{op_q[1][3], op_q[1][2], op_q[1][1], op_q[1][0]},
                           {op_q[0][3], op_q[0][2], op_q[0][1], op_q[0][0]}};

   wire [7:0][17:0] p9;
   for (genvar i = 0; i < `DMUL_LANES; i++) begin : g_m9
      dmul_mul #(.W(`DMUL_W9)) u_m9 (
         .a_in  (op_q[0][i]),
         .b_in  (op_q[1][i]),
         .sa_in (sa),
         .sb_in (sb),
         .p_out (p9[i])
      );
   end

   wire [3:0][17:0] m_a;
   wire [3:0][17:0] m_b;
   wire [3:0]       m_sa;
   wire [3:0]       m_sb;
   wire [3:0][35:0] p18;
   wire [3:0][35:0] st_d;
   wire [3:0][35:0] st_q;
   for (genvar g = 0; g < `DMUL_GROUPS; g++) begin : g_m18
      // Wide mode: group bit 0 picks high A half, bit 1 high B half
      assign m_a[g]  = is36 ? o36[0][18*(g%2) +: 18]
                            : {op_q[0][2*g+1], op_q[0][2*g]};
      assign m_b[g]  = is36 ? o36[1][18*(g/2) +: 18]
                            : {op_q[1][2*g+1], op_q[1][2*g]};
      assign m_sa[g] = is36 ? (sa & (g % 2 == 1)) : sa;
      assign m_sb[g] = is36 ? (sb & (g / 2 == 1)) : sb;
      dmul_mul #(.W(`DMUL_W18)) u_m18 (
         .a_in  (m_a[g]),
         .b_in  (m_b[g]),
         .sa_in (m_sa[g]),
         .sb_in (m_sb[g]),
         .p_out (p18[g])
      );
      assign st_d[g] = is9 ? {p9[2*g+1], p9[2*g]} : p18[g];
      // In wide mode all partials share group 0's choice to stay aligned
      dmul_reg #(.W(`DMUL_W36)) u_pipe (
         .ctl        (ctl),
         .use_in     (is36 ? pipe_use_in[0] : pipe_use_in[g]),
         .clk_sel_in (pipe_sel_in[1:0]),
         .clr_sel_in (pipe_sel_in[3:2]),
         .ena_sel_in (pipe_sel_in[5:4]),
         .d_in       (st_d[g]),
         .q_out      (st_q[g]),
         .r_out      ()
      );
   end

   // Signs follow the pipeline so the wide combine extends correctly
   wire [1:0] sgn_p;
   dmul_reg #(.W(2)) u_sign_pipe (
      .ctl        (ctl),
      .use_in     (pipe_use_in[0]),
      .clk_sel_in (pipe_sel_in[1:0]),
      .clr_sel_in (pipe_sel_in[3:2]),
      .ena_sel_in (pipe_sel_in[5:4]),
      .d_in       ({sb, sa}),
      .q_out      (sgn_p),
      .r_out      ()
   );
   wire sa_p = sgn_p[0];
   wire sb_p = sgn_p[1];

   wire [71:0] e1 = {{36{sa_p & st_q[1][35]}}, st_q[1]};
   wire [71:0] e2 = {{36{sb_p & st_q[2][35]}}, st_q[2]};
   wire [71:0] sum72 = {36'h0, st_q[0]}
                     + {e1[53:0], 18'h0}
                     + {e2[53:0], 18'h0}
                     + {st_q[3], 36'h0};

   wire [143:0] result = is36 ? {72'h0, sum72} : st_q;
   wire [143:0] next_direct = route_adder_in ? 144'h0 : result;
   wire [143:0] next_adder  = route_adder_in ? result : 144'h0;

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         direct_out         <= '0;
         adder_out          <= '0;
         product_signed_out <= 1'b0;
         width_a_out        <= '0;
         width_b_out        <= '0;
      end else begin
         direct_out         <= next_direct;
         adder_out          <= next_adder;
         product_signed_out <= sa_p | sb_p;
         width_a_out        <= wlim(sign_src_a_in, sign_src_b_in);
         width_b_out        <= wlim(sign_src_b_in, sign_src_a_in);
      end
   end

   // Reference products for the checks below
   wire [35:0] chk18 = m_a[0] * m_b[0];
   wire [71:0] chk36 = o36[0] * o36[1];

   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!rstn_in);

   property p_signed;
      (!pipe_use_in[0] && ((sign_src_a_in == dmul_pkg::DMUL_SRC_SGN) ||
                           (sign_src_b_in == dmul_pkg::DMUL_SRC_SGN)))
         |=> product_signed_out;
   endproperty
   a_signed: assert property (p_signed)
      else $error("product sign flag wrong");

   property p_unsigned;
      (!pipe_use_in[0] && (sign_src_a_in == dmul_pkg::DMUL_SRC_UNS) &&
       (sign_src_b_in == dmul_pkg::DMUL_SRC_UNS)) |=> !product_signed_out;
   endproperty
   a_unsigned: assert property (p_unsigned)
      else $error("unsigned product flagged signed");

   property p_no36_shift;
      is36 |-> (op_d == op_in);
   endproperty
   a_no36_shift: assert property (p_no36_shift)
      else $error("shift active in wide mode");

   property p_route_adder;
      (adder_out != 144'h0) |-> $past(route_adder_in);
   endproperty
   a_route_adder: assert property (p_route_adder)
      else $error("adder port fed while routed direct");

   property p_route_direct;
      route_adder_in |=> (direct_out == 144'h0);
   endproperty
   a_route_direct: assert property (p_route_direct)
      else $error("direct output fed while routed to adder");

   property p_w_matched;
      (sign_src_a_in == sign_src_b_in) |=>
         (width_a_out == `DMUL_LIM_FULL) && (width_b_out == `DMUL_LIM_FULL);
   endproperty
   a_w_matched: assert property (p_w_matched)
      else $error("matched signs must allow 36 bits");

   property p_w_split;
      (sign_src_a_in == dmul_pkg::DMUL_SRC_DYN_A &&
       sign_src_b_in == dmul_pkg::DMUL_SRC_DYN_B) |=>
         (width_a_out == `DMUL_LIM_CUT) && (width_b_out == `DMUL_LIM_CUT);
   endproperty
   a_w_split: assert property (p_w_split)
      else $error("separate dynamic signs must cap both at 35");

   property p_full18;
      (mode_in == dmul_pkg::DMUL_M18 && !pipe_use_in[0] && !route_adder_in
       && !sa && !sb) |=> (direct_out[35:0] == $past(chk18));
   endproperty
   a_full18: assert property (p_full18)
      else $error("18-bit product not full precision");

   property p_wide;
      (is36 && !pipe_use_in[0] && !route_adder_in && !sa_p && !sb_p)
         |=> (direct_out[71:0] == $past(chk36));
   endproperty
   a_wide: assert property (p_wide)
      else $error("wide product combine wrong");
endmodule

// File: shared/dmul_cfg.svh
// Purpose: constants of the multiplier stage
// Assumes: included by bare name
// Notes:   widths, lane counts and limit figures
`ifndef DMUL_CFG_SVH
`define DMUL_CFG_SVH
`define DMUL_W9        9
`define DMUL_W18       18
`define DMUL_W36       36
`define DMUL_LANES     8
`define DMUL_GROUPS    4
`define DMUL_CHAIN_MAX 224
`define DMUL_LIM_FULL  6'h24
`define DMUL_LIM_CUT   6'h23
`define DMUL_OUT_W     144
`endif

// File: shared/dmul_pkg.sv
// Purpose: types of the multiplier stage
// Assumes: nothing
// Notes:   mode code 2'h3 is illegal and acts as the 18-bit mode
package dmul_pkg;
   typedef enum logic [1:0] {
      DMUL_M9  = 2'b00,
      DMUL_M18 = 2'b01,
      DMUL_M36 = 2'b10
   } dmul_mode_t;
   typedef enum logic [1:0] {
      DMUL_SRC_UNS   = 2'b00,
      DMUL_SRC_SGN   = 2'b01,
      DMUL_SRC_DYN_A = 2'b10,
      DMUL_SRC_DYN_B = 2'b11
   } dmul_sgn_src_t;
endpackage

// File: shared/dmul_ctl_if.sv
// Purpose: shared clock strobes, clears and enables of the block
// Assumes: one system clock
// Notes:   the four shared clocks are strobes sampled on clk
`timescale 1ns/1ps
interface dmul_ctl_if (
   input wire logic clk,
   input wire logic rstn
);
   logic [3:0] tick;
   logic [3:0] aclr;
   logic [3:0] ena;
   modport src  (input clk, input rstn, output tick, output aclr, output ena);
   modport sink (input clk, input rstn, input tick, input aclr, input ena);
endinterface

// File: logic/dmul_reg.sv
// Purpose: optional register with selected strobe, clear and enable
// Assumes: selects are static while the register runs
// Notes:   q is the register when used, else the input passes through
`timescale 1ns/1ps
`include "dmul_cfg.svh"
module dmul_reg #(
   parameter int W = 9
) (
   dmul_ctl_if.sink          ctl,
   input  wire logic         use_in,
   input  wire logic [1:0]   clk_sel_in,
   input  wire logic [1:0]   clr_sel_in,
   input  wire logic [1:0]   ena_sel_in,
   input  wire logic [W-1:0] d_in,
   output logic      [W-1:0] q_out,
   output logic      [W-1:0] r_out
);
   // Changing clr_sel while running may pulse the clear
   wire clr_n = ctl.rstn & ~ctl.aclr[clr_sel_in];
   wire take  = ctl.tick[clk_sel_in] & ctl.ena[ena_sel_in];

   always_ff @(posedge ctl.clk or negedge clr_n) begin
      if (!clr_n) begin
         r_out <= '0;
      end else if (take) begin
         r_out <= d_in;
      end
   end

   assign q_out = use_in ? r_out : d_in;

   property p_hold;
      @(posedge ctl.clk) disable iff (!clr_n)
      !take |=> $stable(r_out);
   endproperty
   a_hold: assert property (p_hold)
      else $error("register changed without strobe and enable");
endmodule

// File: logic/dmul_mul.sv
// Purpose: full-precision multiplier with per-operand sign
// Assumes: sign inputs are 1 for two's complement
// Notes:   one extra bit per operand covers all sign mixes
`timescale 1ns/1ps
module dmul_mul #(
   parameter int W = 9
) (
   input  wire logic [W-1:0]   a_in,
   input  wire logic [W-1:0]   b_in,
   input  wire logic           sa_in,
   input  wire logic           sb_in,
   output logic      [2*W-1:0] p_out
);
   wire signed [W:0]     ae   = {sa_in & a_in[W-1], a_in};
   wire signed [W:0]     be   = {sb_in & b_in[W-1], b_in};
   wire signed [2*W+1:0] full = ae * be;

   // Low 2W bits are exact for every sign mix
   assign p_out = full[2*W-1:0];
endmodule

// File: verification/dmul_chain_src.sv
// Purpose: model of the preceding block's chain outputs
// Assumes: load and words driven by the bench on the falling edge
// Notes:   holds its last word, as a real neighbour register does
`timescale 1ns/1ps
module dmul_chain_src (
   input  wire logic        clk_in,
   input  wire logic        rstn_in,
   input  wire logic        load_in,
   input  wire logic [17:0] word_a_in,
   input  wire logic [17:0] word_b_in,
   output logic      [17:0] chain_a_out,
   output logic      [17:0] chain_b_out
);
   // Registered stage; wide-mode shift registers must live out here
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         chain_a_out <= 18'h00000;
         chain_b_out <= 18'h00000;
      end else if (load_in) begin
         chain_a_out <= word_a_in;
         chain_b_out <= word_b_in;
      end
   end
endmodule

// File: verification/dmul_stage_tb.sv
// Purpose: self-checking bench of the multiplier stage
// Assumes: configuration changes only between scenarios
// Notes:   products are rebuilt here from sign-extended operands
`timescale 1ns/1ps
`include "dmul_cfg.svh"
module dmul_stage_tb;
   logic                    clk_in;
   logic                    rstn_in;
   logic [3:0]              tick, aclr, ena, ua, ub, puse;
   dmul_pkg::dmul_mode_t    mode;
   dmul_pkg::dmul_sgn_src_t ssa, ssb;
   logic [71:0]             a, b;
   logic [17:0]             cha, chb, pva, pvb, coa, cob;
   logic [7:0]              sha, shb, acs, acl, aen, bcs, bcl, ben;
   logic                    sga, sgb, sur, radd, pld, psg;
   logic [5:0]              ssel, psel, wa, wb;
   logic [143:0]            dout, aout;
   logic [35:0]             pe [4];
   int                      miscompares, compares, cycles, i, k, s;
   // Entries {src a, src b}, and the expected cut flags {a, b}
   logic [39:0]             srcs = 40'hAB83974150;
   logic [19:0]             cuts = 20'h36960;

   dmul_chain_src u_dmul_chain_src (.clk_in(clk_in), .rstn_in(rstn_in),
      .load_in(pld), .word_a_in(pva), .word_b_in(pvb),
      .chain_a_out(cha), .chain_b_out(chb));

   dmul_stage u_dmul_stage (.clk_in(clk_in), .rstn_in(rstn_in),
      .clk_tick_in(tick), .aclr_in(aclr), .ena_in(ena), .mode_in(mode),
      .a_in(a), .b_in(b), .chain_in_a_in(cha), .chain_in_b_in(chb),
      .a_use_reg_in(ua), .b_use_reg_in(ub), .a_shift_in(sha),
      .b_shift_in(shb), .a_clk_sel_in(acs), .a_clr_sel_in(acl),
      .a_ena_sel_in(aen), .b_clk_sel_in(bcs), .b_clr_sel_in(bcl),
      .b_ena_sel_in(ben), .sign_a_in(sga), .sign_b_in(sgb),
      .sign_src_a_in(ssa), .sign_src_b_in(ssb), .sign_use_reg_in(sur),
      .sign_sel_in(ssel), .pipe_use_in(puse), .pipe_sel_in(psel),
      .route_adder_in(radd), .chain_out_operand_a_out(coa),
      .chain_out_operand_b_out(cob), .direct_out(dout), .adder_out(aout),
      .product_signed_out(psg), .width_a_out(wa), .width_b_out(wb));

   function automatic logic [71:0] mref(input logic [35:0] x, y,
                                        input logic sx, sy, input int w);
      logic signed [73:0] p, q, r;
      p = {38'h0, x};
      q = {38'h0, y};
      if (sx && x[w-1]) p = p - (74'sh1 <<< w);
      if (sy && y[w-1]) q = q - (74'sh1 <<< w);
      r = p * q;
      return r[71:0] & ((72'h1 << (2 * w)) - 72'h1);
   endfunction

   function automatic logic rs(input logic [1:0] c);
      return (c == 2'h0) ? 1'b0 : (c == 2'h1) ? 1'b1 : (c == 2'h2) ? sga : sgb;
   endfunction

   task automatic chk(input logic [143:0] got, exp);
      compares++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected at %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(negedge clk_in);
   endtask

   task automatic test_done;
      if (miscompares == 0 && compares > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   initial begin
      clk_in = 1'b0;
      forever #25 clk_in = ~clk_in;
   end

   // Whole run needs well under a hundred cycles
   always @(posedge clk_in) begin
      cycles++;
      if (cycles == 400) begin
         miscompares++;
         test_done();
      end
   end

   initial begin
      {tick, aclr, ena, ua, ub, puse, a, b, pva, pvb, sha, shb} = '0;
      {acs, acl, aen, bcs, bcl, ben, sga, sgb, sur, radd, pld} = '0;
      {ssel, psel} = '0;
      mode = dmul_pkg::DMUL_M9;
      ssa = dmul_pkg::DMUL_SRC_DYN_A;
      ssb = dmul_pkg::DMUL_SRC_DYN_B;
      rstn_in = 1'b0;
      cyc(2);
      rstn_in = 1'b1;
      // Eight narrow lanes, unregistered, every sign mix
      for (i = 0; i < 8; i++) begin
         a[9*i+:9] = 9'h1F0 + 9'(i);
         b[9*i+:9] = 9'h00F + 9'(i) * 9'h021;
      end
      for (s = 0; s < 4; s++) begin
         sga = s[1];
         sgb = s[0];
         cyc(1);
         for (i = 0; i < 8; i++)
            chk(dout[18*i+:18],
                mref(36'(a[9*i+:9]), 36'(b[9*i+:9]), sga, sgb, 9));
         chk(psg, sga | sgb);
         chk(aout, 144'h0);
      end
      // Four groups through pipe and sign registers to the adder port
      // Code 3 is illegal and must behave as the 18-bit mode
      mode = dmul_pkg::dmul_mode_t'(2'h3);
      ssa = dmul_pkg::DMUL_SRC_SGN;
      ssb = dmul_pkg::DMUL_SRC_SGN;
      {radd, sur, puse, tick, ena} = {1'b1, 1'b1, 4'hF, 4'h1, 4'h1};
      for (k = 0; k < 2; k++) begin
         for (i = 0; i < 4; i++) begin
            a[18*i+:18] = 18'h20000 + 18'(i + k);
            b[18*i+:18] = 18'h3FFFF - 18'(i * 3 + k);
         end
         cyc(1);
         if (k == 1)
            for (i = 0; i < 4; i++) chk(aout[36*i+:36], pe[i]);
         cyc(2);
         for (i = 0; i < 4; i++) begin
            pe[i] = 36'(mref(36'(a[18*i+:18]), 36'(b[18*i+:18]),
                             1'b1, 1'b1, 18));
            chk(aout[36*i+:36], pe[i]);
         end
         chk(dout, 144'h0);
         chk(psg, 1'b1);
      end
      // Wide mode: shift select must be ignored, limits per sign source
      mode = dmul_pkg::DMUL_M36;
      {radd, ua, sha, pld} = {1'b0, 4'hF, 8'hFF, 1'b1};
      pva = 18'h2AAAA;
      pvb = 18'h15555;
      a = {36'h0, 36'h800000001};
      b = {36'h0, 36'hFFFFFFFFE};
      sga = 1'b1;
      sgb = 1'b0;
      for (k = 0; k < 10; k++) begin
         ssa = dmul_pkg::dmul_sgn_src_t'(srcs[4*k+2+:2]);
         ssb = dmul_pkg::dmul_sgn_src_t'(srcs[4*k+:2]);
         // Even passes bypass the pipe register, odd ones use it
         puse = k[0] ? 4'hF : 4'h0;
         cyc(4);
         chk(dout, {72'h0,
                    mref(a[35:0], b[35:0], rs(ssa), rs(ssb), 36)});
         chk(wa, cuts[2*k+1] ? `DMUL_LIM_CUT : `DMUL_LIM_FULL);
         chk(wb, cuts[2*k] ? `DMUL_LIM_CUT : `DMUL_LIM_FULL);
      end
      // A shifts on strobe 1, B loads parallel on strobe 2, clear on 3
      mode = dmul_pkg::DMUL_M18;
      ssa = dmul_pkg::DMUL_SRC_UNS;
      ssb = dmul_pkg::DMUL_SRC_UNS;
      {puse, sur, ub, sha, shb} = {4'h0, 1'b0, 4'hF, 8'h55, 8'h00};
      {acs, aen, bcs, ben, acl, bcl} = {8'h55, 8'h55, 8'hAA, 8'hAA, 16'hFFFF};
      {tick, ena, aclr} = {4'h0, 4'hF, 4'h8};
      b[71:54] = 18'h00123;
      cyc(1);
      aclr = 4'h0;
      tick = 4'h2;
      for (k = 0; k < 5; k++) begin
         pva = 18'h01000 + 18'(k);
         cyc(1);
      end
      chk(coa, 18'h01000);
      chk(cob, 18'h00000);
      ena = 4'hD;
      cyc(1);
      chk(coa, 18'h01000);
      {tick, ena} = {4'h4, 4'hF};
      cyc(1);
      chk(cob, 18'h00123);
      chk(coa, 18'h01000);
      tick = 4'h0;
      cyc(2);
      chk(dout[143:108], mref(36'h1000, 36'h123, 1'b0, 1'b0, 18));
      aclr = 4'h8;
      #1;
      chk(coa, 18'h00000);
      chk(cob, 18'h00000);
      test_done();
   end
endmodule
